// ===== cidt_pkg.sv
// Shared constants, types and encodings for the instruction decode core.
// Assumes one clock and a synchronous active-high reset in every user.
package cidt_pkg;

    // =========================================================
    // Widths and timing
    localparam int INSTR_W = 14;
    localparam int F_W = 7;
    localparam int DATA_W = 8;
    localparam int REG_W = 16;
    localparam int PHASES = 4;

    // =========================================================
    // Quarter-cycle phases of one instruction cycle
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } cidt_phase_t;

    // Group from the two top opcode bits
    typedef enum logic [1:0] {
        GRP_BYTE = 2'b00,
        GRP_BIT = 2'b01,
        GRP_JUMP = 2'b10,
        GRP_LIT = 2'b11
    } cidt_group_t;

    // =========================================================
    // Byte-oriented operation codes, bits 11:8
    localparam logic [3:0] OP_MOVWF = 4'h0;
    localparam logic [3:0] OP_CLR = 4'h1;
    localparam logic [3:0] OP_SUB = 4'h2;
    localparam logic [3:0] OP_DEC = 4'h3;
    localparam logic [3:0] OP_IOR = 4'h4;
    localparam logic [3:0] OP_AND = 4'h5;
    localparam logic [3:0] OP_XOR = 4'h6;
    localparam logic [3:0] OP_ADD = 4'h7;
    localparam logic [3:0] OP_MOV = 4'h8;
    localparam logic [3:0] OP_COM = 4'h9;
    localparam logic [3:0] OP_INC = 4'hA;
    localparam logic [3:0] OP_DECSZ = 4'hB;
    localparam logic [3:0] OP_RRF = 4'hC;
    localparam logic [3:0] OP_RLF = 4'hD;
    localparam logic [3:0] OP_SWAP = 4'hE;
    localparam logic [3:0] OP_INCSZ = 4'hF;

    // Control codes in the low seven bits when bits 13:7 are zero
    localparam logic [6:0] CTL_RETURN = 7'h08;
    localparam logic [6:0] CTL_RETFIE = 7'h09;
    localparam logic [6:0] CTL_SLEEP = 7'h63;
    localparam logic [6:0] CTL_CLRWDT = 7'h64;

    // =========================================================
    // Register port map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_WREG = 8'h08;
    localparam logic [7:0] REG_PC = 8'h0C;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_PSA_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [13:0] INSTR_RESET = 14'h0000;

    // Decoded instruction fields
    typedef struct packed {
        cidt_group_t group;
        logic [3:0] op;
        logic dest;
        logic [F_W-1:0] faddr;
        logic [2:0] bsel;
        logic [7:0] k8;
        logic [10:0] k11;
    } cidt_decode_t;

    typedef struct packed {
        logic zero;
        logic nibble_carry;
        logic carry;
    } cidt_flags_t;

    localparam cidt_flags_t FLAGS_RESET = 3'h0;

endpackage

// ===== cidt_core.sv
// Instruction decode and cycle sequencer for a 14-bit-word 8-bit core.
// Assumes program memory answers prog_addr by phase Q4 and the file
// side returns read data in the cycle after file_rd_en, held through Q3.
`timescale 1ns/1ns

module cidt_core #(
    parameter int PC_W = 11,
    parameter int STACK_DEPTH = 8,
    parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01,
    parameter logic [6:0] PORT_ADDR_A = 7'h05,
    parameter logic [6:0] PORT_ADDR_B = 7'h07
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [13:0] instr_word,
    output logic [6:0] file_addr,
    output logic file_rd_en,
    output logic file_rd_from_pins,
    input wire logic [7:0] file_rd_data,
    output logic file_wr_en,
    output logic [7:0] file_wr_data,
    output logic pin_change_mismatch_clear,
    output logic prescaler_clear,
    output logic wdt_clear,
    output logic sleep_req,
    output logic cycle_start,
    output logic [7:0] w_value,
    output logic timeout_flag,
    output logic powerdown_flag
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    cidt_pkg::cidt_phase_t phase;
    cidt_pkg::cidt_decode_t dec;
    cidt_pkg::cidt_flags_t flags;
    cidt_pkg::cidt_flags_t next_flags;
    cidt_pkg::cidt_flags_t flags_q3;
    logic [1:0] ctrl;
    logic run;
    logic [13:0] instr_reg;
    logic flush;
    logic exec;
    logic [PC_W-1:0] pc;
    logic [PC_W-1:0] stack_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp;
    logic [7:0] w;
    logic [7:0] opnd;
    logic [7:0] addend;
    logic [7:0] mask;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic is_sub;
    logic [7:0] next_res;
    logic [7:0] res_q3;
    logic next_skip;
    logic skip_q3;
    logic names_file;
    logic wr_file;
    logic wr_w;
    logic do_goto;
    logic do_call;
    logic do_ret;
    logic is_retfie;
    logic is_sleep;
    logic is_clrwdt;
    logic is_port;
    logic gie;
    logic q4_tick;

    assign run = ctrl[cidt_pkg::CTRL_RUN_BIT];
    assign q4_tick = run && (phase == cidt_pkg::PH_Q4);
    assign exec = !flush;

    // =========================================================
    // Quarter-cycle sequencer
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase <= cidt_pkg::PH_Q1;
        end else if (run) begin
            unique case (phase)
                cidt_pkg::PH_Q1: phase <= cidt_pkg::PH_Q2;
                cidt_pkg::PH_Q2: phase <= cidt_pkg::PH_Q3;
                cidt_pkg::PH_Q3: phase <= cidt_pkg::PH_Q4;
                cidt_pkg::PH_Q4: phase <= cidt_pkg::PH_Q1;
            endcase
        end
    end

    assign cycle_start = run && (phase == cidt_pkg::PH_Q1);

    // =========================================================
    // Field split
    always_comb begin
        dec.group = cidt_pkg::cidt_group_t'(instr_reg[13:12]);
        dec.op = instr_reg[11:8];
        dec.dest = instr_reg[7];
        dec.faddr = instr_reg[6:0];
        dec.bsel = instr_reg[9:7];
        dec.k8 = instr_reg[7:0];
        dec.k11 = instr_reg[10:0];
    end

    assign file_addr = dec.faddr;
    assign is_port = (dec.faddr == PORT_ADDR_A) || (dec.faddr == PORT_ADDR_B);

    // =========================================================
    // Group and control decode
    always_comb begin
        names_file = 1'b0;
        wr_file = 1'b0;
        wr_w = 1'b0;
        do_goto = 1'b0;
        do_call = 1'b0;
        do_ret = 1'b0;
        is_retfie = 1'b0;
        is_sleep = 1'b0;
        is_clrwdt = 1'b0;
        unique case (dec.group)
            cidt_pkg::GRP_BYTE: begin
                if (dec.op == cidt_pkg::OP_MOVWF && !dec.dest) begin
                    // Unlisted low codes fall to no-op
                    do_ret = (dec.faddr == cidt_pkg::CTL_RETURN)
                        || (dec.faddr == cidt_pkg::CTL_RETFIE);
                    is_retfie = dec.faddr == cidt_pkg::CTL_RETFIE;
                    is_sleep = dec.faddr == cidt_pkg::CTL_SLEEP;
                    is_clrwdt = dec.faddr == cidt_pkg::CTL_CLRWDT;
                end else if (dec.op == cidt_pkg::OP_CLR && !dec.dest) begin
                    wr_w = 1'b1;
                end else begin
                    names_file = 1'b1;
                    wr_file = dec.dest;
                    wr_w = !dec.dest;
                end
            end
            cidt_pkg::GRP_BIT: begin
                names_file = 1'b1;
                wr_file = !dec.op[3];
            end
            cidt_pkg::GRP_JUMP: begin
                do_goto = dec.op[3];
                do_call = !dec.op[3];
            end
            cidt_pkg::GRP_LIT: begin
                wr_w = (dec.op != 4'hB);
                do_ret = (dec.op[3:2] == 2'b01);
            end
        endcase
    end

    // =========================================================
    // Arithmetic and logic
    assign opnd = (dec.group == cidt_pkg::GRP_LIT) ? dec.k8 : file_rd_data;
    assign is_sub = ((dec.group == cidt_pkg::GRP_BYTE) && (dec.op == cidt_pkg::OP_SUB))
        || ((dec.group == cidt_pkg::GRP_LIT) && (dec.op[3:1] == 3'b110));
    assign addend = is_sub ? ~w : w;
    assign sum9 = {1'b0, opnd} + {1'b0, addend} + {8'h00, is_sub};
    assign nib5 = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
    assign mask = 8'h01 << dec.bsel;

    always_comb begin
        next_res = 8'h00;
        next_flags = flags;
        next_skip = 1'b0;
        unique case (dec.group)
            cidt_pkg::GRP_BYTE: begin
                unique case (dec.op)
                    cidt_pkg::OP_MOVWF: next_res = w;
                    cidt_pkg::OP_CLR: next_res = 8'h00;
                    cidt_pkg::OP_SUB,
                    cidt_pkg::OP_ADD: begin
                        next_res = sum9[7:0];
                        next_flags.carry = sum9[8];
                        next_flags.nibble_carry = nib5[4];
                    end
                    cidt_pkg::OP_DEC,
                    cidt_pkg::OP_DECSZ: next_res = opnd - 8'h01;
                    cidt_pkg::OP_IOR: next_res = opnd | w;
                    cidt_pkg::OP_AND: next_res = opnd & w;
                    cidt_pkg::OP_XOR: next_res = opnd ^ w;
                    cidt_pkg::OP_MOV: next_res = opnd;
                    cidt_pkg::OP_COM: next_res = ~opnd;
                    cidt_pkg::OP_INC,
                    cidt_pkg::OP_INCSZ: next_res = opnd + 8'h01;
                    cidt_pkg::OP_RRF: begin
                        next_res = {flags.carry, opnd[7:1]};
                        next_flags.carry = opnd[0];
                    end
                    cidt_pkg::OP_RLF: begin
                        next_res = {opnd[6:0], flags.carry};
                        next_flags.carry = opnd[7];
                    end
                    cidt_pkg::OP_SWAP: next_res = {opnd[3:0], opnd[7:4]};
                endcase
                // Zero untouched by MOVWF, skips, rotates and swap
                if (!(dec.op inside {cidt_pkg::OP_MOVWF, cidt_pkg::OP_DECSZ,
                        cidt_pkg::OP_INCSZ, cidt_pkg::OP_RRF, cidt_pkg::OP_RLF,
                        cidt_pkg::OP_SWAP}) && (names_file || wr_w)) begin
                    next_flags.zero = (next_res == 8'h00);
                end
                if (dec.op == cidt_pkg::OP_DECSZ || dec.op == cidt_pkg::OP_INCSZ) begin
                    next_skip = (next_res == 8'h00);
                end
            end
            cidt_pkg::GRP_BIT: begin
                unique case (dec.op[3:2])
                    2'b00: next_res = opnd & ~mask;
                    2'b01: next_res = opnd | mask;
                    2'b10: next_skip = !opnd[dec.bsel];
                    2'b11: next_skip = opnd[dec.bsel];
                endcase
            end
            cidt_pkg::GRP_JUMP: next_res = w;
            cidt_pkg::GRP_LIT: begin
                unique casez (dec.op)
                    4'b00??,
                    4'b01??: next_res = dec.k8;
                    4'b11??: begin
                        next_res = sum9[7:0];
                        next_flags.carry = sum9[8];
                        next_flags.nibble_carry = nib5[4];
                        next_flags.zero = (sum9[7:0] == 8'h00);
                    end
                    4'b1000: next_res = dec.k8 | w;
                    4'b1001: next_res = dec.k8 & w;
                    4'b1010: next_res = dec.k8 ^ w;
                    default: next_res = w;
                endcase
                if ((dec.op[3:2] == 2'b10) && (dec.op[1:0] != 2'b11)) begin
                    next_flags.zero = (next_res == 8'h00);
                end
            end
        endcase
    end

    // Result captured at the end of Q3, after read data has settled
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            res_q3 <= 8'h00;
            flags_q3 <= cidt_pkg::FLAGS_RESET;
            skip_q3 <= 1'b0;
        end else if (run && phase == cidt_pkg::PH_Q3) begin
            res_q3 <= next_res;
            flags_q3 <= next_flags;
            skip_q3 <= next_skip;
        end
    end

    // =========================================================
    // File side strobes
    // Read issued for clears too; the port read side effect is intended
    assign file_rd_en = run && (phase == cidt_pkg::PH_Q2) && names_file && exec;
    assign file_rd_from_pins = file_rd_en && is_port;
    assign pin_change_mismatch_clear = file_rd_en && is_port;
    assign file_wr_en = q4_tick && wr_file && exec;
    assign file_wr_data = res_q3;
    assign prescaler_clear = file_wr_en && (dec.faddr == TIMER_ZERO_ADDR)
        && ctrl[cidt_pkg::CTRL_PSA_BIT];
    assign wdt_clear = q4_tick && exec && is_clrwdt;
    assign sleep_req = q4_tick && exec && is_sleep;

    // =========================================================
    // Working register and flags
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            w <= 8'h00;
        end else if (q4_tick && exec && wr_w) begin
            w <= res_q3;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            flags <= cidt_pkg::FLAGS_RESET;
        end else if (q4_tick && exec) begin
            flags <= flags_q3;
        end
    end

    // Power flags start set; sleep and watchdog clear rewrite them
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (q4_tick && exec && (is_sleep || is_clrwdt)) begin
            timeout_flag <= 1'b1;
            powerdown_flag <= is_clrwdt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gie <= 1'b0;
        end else if (q4_tick && exec && is_retfie) begin
            gie <= 1'b1;
        end
    end

    assign w_value = w;

    // =========================================================
    // Fetch, program counter and stack
    // Stack wraps silently on overflow, as a hardware stack does
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc <= '0;
            sp <= '0;
        end else if (q4_tick) begin
            if (exec && (do_goto || do_call)) begin
                pc <= PC_W'(dec.k11);
            end else if (exec && do_ret) begin
                pc <= stack_mem[sp - 1'b1];
            end else begin
                pc <= pc + 1'b1;
            end
            if (exec && do_call) begin
                sp <= sp + 1'b1;
            end else if (exec && do_ret) begin
                sp <= sp - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (q4_tick && exec && do_call) begin
            stack_mem[sp] <= pc;
        end
    end

    assign prog_addr = pc;

    // Fetched word discarded as a no-op after a taken branch or skip
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            instr_reg <= cidt_pkg::INSTR_RESET;
            flush <= 1'b1;
        end else if (q4_tick) begin
            instr_reg <= instr_word;
            flush <= exec && (do_goto || do_call || do_ret || skip_q3);
        end
    end

    // =========================================================
    // Register port
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl <= cidt_pkg::CTRL_RESET;
        end else if (reg_wr && reg_addr == cidt_pkg::REG_CTRL) begin
            ctrl <= reg_wdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                unique case (reg_addr)
                    cidt_pkg::REG_CTRL: reg_rdata <= {14'h0000, ctrl};
                    cidt_pkg::REG_STATUS: reg_rdata <= {5'h00, phase, gie, flush,
                        instr_reg[13:12], timeout_flag, powerdown_flag, flags};
                    cidt_pkg::REG_WREG: reg_rdata <= {8'h00, w};
                    cidt_pkg::REG_PC: reg_rdata <= 16'(pc);
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

endmodule

// ===== cidt_core_monitor.sv
// Concurrent checks on the ports of the instruction decode core.
// Assumes one clock, synchronous active-high reset, run bit left set.
`timescale 1ns/1ns
module cidt_core_monitor #(
    parameter int PC_W = 11,
    parameter logic [6:0] TIMER_ZERO_ADDR = 7'h01,
    parameter logic [6:0] PORT_ADDR_A = 7'h05,
    parameter logic [6:0] PORT_ADDR_B = 7'h07
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    input wire logic file_rd_from_pins,
    input wire logic file_wr_en,
    input wire logic pin_change_mismatch_clear,
    input wire logic prescaler_clear,
    input wire logic wdt_clear,
    input wire logic sleep_req,
    input wire logic cycle_start,
    input wire logic [7:0] w_value
);
    default clocking mon_cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic is_port;
    assign is_port = (file_addr == PORT_ADDR_A) || (file_addr == PORT_ADDR_B);
    // ==========================================
    // Assertions
    // Phase sits in Q1 through reset, so the release edge itself is a slot start
    AST_SLOT_FOUR: assert property ((cycle_start && !sys_rst)
        |=> !cycle_start [*3] ##1 cycle_start)
        else $error("cycle_start spacing not four clocks");
    AST_RD_IN_Q2: assert property (file_rd_en |-> $past(cycle_start))
        else $error("file read not in second quarter");
    AST_WR_AFTER_RD: assert property (file_wr_en |-> $past(file_rd_en, 2))
        else $error("file write without read two clocks before");
    AST_WR_ONCE: assert property (file_wr_en |=> !file_wr_en [*3])
        else $error("more than one file write per slot");
    AST_PIN_READ: assert property (file_rd_from_pins == (file_rd_en && is_port))
        else $error("port read not taken from pins");
    AST_MISMATCH: assert property (pin_change_mismatch_clear == (file_rd_en && is_port))
        else $error("mismatch clear not tied to port read");
    AST_PRESCALE: assert property (prescaler_clear |-> file_wr_en && file_addr == TIMER_ZERO_ADDR)
        else $error("prescaler clear without timer write");
    AST_W_COMMIT: assert property (!$stable(w_value) |-> cycle_start)
        else $error("working register changed mid slot");
    AST_PC_COMMIT: assert property (!$stable(prog_addr) |-> cycle_start)
        else $error("program counter changed mid slot");
    AST_FLUSH: assert property (!$stable(prog_addr) && prog_addr != PC_W'($past(prog_addr) + 1'b1)
        |-> (!file_rd_en && !file_wr_en) [*4])
        else $error("strobe inside flushed slot");
    AST_CTL_Q4: assert property ((wdt_clear || sleep_req) |=> cycle_start)
        else $error("control pulse not in last quarter");
    // ==========================================
    // Coverage
    COV_PIN: cover property (file_rd_from_pins);
    COV_PSC: cover property (prescaler_clear);
    COV_WDT: cover property (wdt_clear);
    COV_WR: cover property (file_wr_en);
endmodule

bind cidt_core cidt_core_monitor #(.PC_W(PC_W), .TIMER_ZERO_ADDR(TIMER_ZERO_ADDR),
    .PORT_ADDR_A(PORT_ADDR_A), .PORT_ADDR_B(PORT_ADDR_B)) cidt_core_monitor_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .prog_addr(prog_addr), .file_addr(file_addr),
    .file_rd_en(file_rd_en), .file_rd_from_pins(file_rd_from_pins), .file_wr_en(file_wr_en),
    .pin_change_mismatch_clear(pin_change_mismatch_clear), .prescaler_clear(prescaler_clear),
    .wdt_clear(wdt_clear), .sleep_req(sleep_req), .cycle_start(cycle_start), .w_value(w_value));

// ===== cidt_mem_model.sv
// Program memory and file register model facing the decode core.
// Assumes reads strobed in Q2 and writes in Q4; the bench presets rom and ram.
`timescale 1ns/1ns
module cidt_mem_model (
    input wire logic ref_clk,
    input wire logic [10:0] prog_addr,
    output logic [13:0] instr_word,
    input wire logic [6:0] file_addr,
    input wire logic file_rd_en,
    input wire logic file_rd_from_pins,
    output logic [7:0] file_rd_data,
    input wire logic file_wr_en,
    input wire logic [7:0] file_wr_data,
    input wire logic [7:0] pin_levels
);
    logic [13:0] rom [0:2047];
    logic [7:0] ram [0:127];
    initial file_rd_data = 8'h00;
    assign instr_word = rom[prog_addr];
    // ==========================================
    // Data stands one cycle only; inverted after so stale reads show up
    always @(posedge ref_clk) begin
        if (file_rd_en) begin
            file_rd_data <= file_rd_from_pins ? pin_levels : ram[file_addr];
        end else begin
            file_rd_data <= ~file_rd_data;
        end
        if (file_wr_en) begin
            ram[file_addr] <= file_wr_data;
        end
    end
endmodule

// ===== tb.sv
// Self-checking bench for the instruction decode core.
// Assumes the memory model holds rom, ram and pin levels.
`timescale 1ns/1ns
module tb;
    typedef struct packed {logic [13:0] ins; logic [7:0] w; logic [7:0] f;} cidt_row_t;
    logic ref_clk, sys_rst, reg_wr, reg_rd, file_rd_en, file_rd_from_pins, file_wr_en;
    logic pcm, psc, wdt, slp, cycle_start, timeout_flag, powerdown_flag;
    logic [7:0] reg_addr, file_rd_data, file_wr_data, w_value, pin_levels;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [10:0] prog_addr;
    logic [13:0] instr_word;
    logic [6:0] file_addr;
    int fail_count = 0, cmp_count = 0, n_pcm, n_psc, n_wdt, n_slp;
    // MOVLW 0x0F runs first, f 0x20 preset to 0x35
    cidt_row_t rows [24] = '{
        '{14'h07A0, 8'h0F, 8'h44}, '{14'h0720, 8'h44, 8'h35}, '{14'h0520, 8'h05, 8'h35},
        '{14'h04A0, 8'h0F, 8'h3F}, '{14'h0620, 8'h3A, 8'h35}, '{14'h01A0, 8'h0F, 8'h00},
        '{14'h09A0, 8'h0F, 8'hCA}, '{14'h0320, 8'h34, 8'h35}, '{14'h0AA0, 8'h0F, 8'h36},
        '{14'h0220, 8'h26, 8'h35}, '{14'h0EA0, 8'h0F, 8'h53}, '{14'h0820, 8'h35, 8'h35},
        '{14'h00A0, 8'h0F, 8'h0F}, '{14'h0D20, 8'h6A, 8'h35}, '{14'h0C20, 8'h1A, 8'h35},
        '{14'h17A0, 8'h0F, 8'hB5}, '{14'h1020, 8'h0F, 8'h34}, '{14'h3355, 8'h55, 8'h35},
        '{14'h39F0, 8'h00, 8'h35}, '{14'h3AFF, 8'hF0, 8'h35}, '{14'h3830, 8'h3F, 8'h35},
        '{14'h3F01, 8'h10, 8'h35}, '{14'h3C20, 8'h11, 8'h35}, '{14'h017F, 8'h00, 8'h35}};

    cidt_core cidt_core_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prog_addr(prog_addr), .instr_word(instr_word), .file_addr(file_addr),
        .file_rd_en(file_rd_en), .file_rd_from_pins(file_rd_from_pins),
        .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
        .pin_change_mismatch_clear(pcm), .prescaler_clear(psc), .wdt_clear(wdt),
        .sleep_req(slp), .cycle_start(cycle_start), .w_value(w_value),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));
    cidt_mem_model cidt_mem_model_i (.ref_clk(ref_clk), .prog_addr(prog_addr),
        .instr_word(instr_word), .file_addr(file_addr), .file_rd_en(file_rd_en),
        .file_rd_from_pins(file_rd_from_pins), .file_rd_data(file_rd_data),
        .file_wr_en(file_wr_en), .file_wr_data(file_wr_data), .pin_levels(pin_levels));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (!sys_rst) begin
            n_pcm += int'(pcm);
            n_psc += int'(psc);
            n_wdt += int'(wdt);
            n_slp += int'(slp);
        end
    end
    // ==========================================
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic load();
        for (int i = 0; i < 16; i++) cidt_mem_model_i.rom[i] = 14'h0000;
        cidt_mem_model_i.ram[7'h20] = 8'h35;
    endtask
    task automatic run(input int cyc);
        sys_rst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        {n_pcm, n_psc, n_wdt, n_slp} = '0;
        sys_rst <= 1'b0;
        repeat (cyc) @(posedge ref_clk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #1_000_000;
        fail_count++;
        finish_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        pin_levels = 8'h5A;
        load();
        run(2);
        check(16'(w_value), 16'h0000);
        reg_read(cidt_pkg::REG_CTRL, rd);
        check(rd, 16'h0001);
        check(rd, 16'h0001);
        reg_read(cidt_pkg::REG_STATUS, rd);
        check(16'(rd[4:3]), 16'h0003);
        reg_write(cidt_pkg::REG_WREG, 16'h00FF);
        reg_read(cidt_pkg::REG_WREG, rd);
        check(rd, 16'h0000);
        reg_read(8'h10, rd);
        check(rd, 16'h0000);
        foreach (rows[i]) begin
            load();
            cidt_mem_model_i.rom[0] = 14'h300F;
            cidt_mem_model_i.rom[1] = rows[i].ins;
            run(32);
            check(16'(w_value), 16'(rows[i].w));
            check(16'(cidt_mem_model_i.ram[7'h20]), 16'(rows[i].f));
        end
        // Skip true, skip false, jump: the word after counts only for skip false
        for (int k = 0; k < 3; k++) begin
            load();
            cidt_mem_model_i.rom[0] = (k == 0) ? 14'h0BA0 : ((k == 1) ? 14'h1820 : 14'h2805);
            cidt_mem_model_i.rom[1] = 14'h30AA;
            cidt_mem_model_i.rom[2] = 14'h3E01;
            cidt_mem_model_i.rom[5] = 14'h3077;
            if (k == 0) cidt_mem_model_i.ram[7'h20] = 8'h01;
            // Stop before the fall-through path reaches word 5
            run(22);
            check(16'(w_value), (k == 0) ? 16'h0001 : ((k == 1) ? 16'h00AB : 16'h0077));
        end
        // Port written as a function of itself, then timer write with and without prescaler assigned
        for (int k = 0; k < 2; k++) begin
            load();
            cidt_mem_model_i.ram[7'h05] = 8'hFF;
            cidt_mem_model_i.ram[7'h01] = 8'h99;
            cidt_mem_model_i.rom[0] = 14'h0885;
            cidt_mem_model_i.rom[4] = 14'h0181;
            run(0);
            if (k == 0) reg_write(cidt_pkg::REG_CTRL, 16'h0003);
            repeat (40) @(posedge ref_clk);
            check(16'(cidt_mem_model_i.ram[7'h05]), 16'h005A);
            check(16'(n_pcm), 16'h0001);
            check(16'(n_psc), (k == 0) ? 16'h0001 : 16'h0000);
            check(16'(cidt_mem_model_i.ram[7'h01]), 16'h0000);
        end
        load();
        cidt_mem_model_i.rom[0] = 14'h0064;
        cidt_mem_model_i.rom[1] = 14'h0063;
        run(11);
        check(16'({n_wdt[0], timeout_flag, powerdown_flag}), 16'h0007);
        repeat (4) @(posedge ref_clk);
        check(16'({n_slp[0], timeout_flag, powerdown_flag}), 16'h0006);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'({timeout_flag, powerdown_flag}), 16'h0003);
        check(16'(prog_addr), 16'h0000);
        finish_test();
    end
endmodule
